// ### inc/eqs_pkg.sv
/*
 holds register offsets, field positions, power-on values and command codes
 shared by the serial equalizer register slave and its host controller.
 assumes nothing beyond a systemverilog compiler.
*/
package eqs_pkg;
    localparam logic [6:0] REG_GENERAL = 7'h00;
    localparam logic [6:0] REG_DRIVER = 7'h01;
    localparam logic [6:0] REG_LAUNCH = 7'h02;
    localparam logic [6:0] REG_CABLE = 7'h03;
    localparam logic [2:0] HOST_CMD = 3'h0;
    localparam logic [2:0] HOST_STATUS = 3'h1;
    localparam logic [2:0] HOST_AUTO = 3'h2;
    localparam logic [2:0] HOST_REACH = 3'h3;
    localparam int CARRIER_BIT = 7;
    localparam int MUTE_BIT = 6;
    localparam int BYPASS_BIT = 5;
    localparam int SLEEP_HI = 4;
    localparam int SLEEP_LO = 3;
    localparam int REACH_BIT = 2;
    localparam int SWING_LO = 5;
    localparam int COMMON_LO = 2;
    localparam int COARSE_BIT = 7;
    localparam int FINE_LO = 3;
    localparam int CABLE_LO = 3;
    localparam logic [7:0] GENERAL_RESET = 8'h08;
    localparam logic [7:0] DRIVER_RESET = 8'h64;
    localparam logic [7:0] LAUNCH_RESET = 8'h00;
    localparam logic [2:0] SWING_700MV = 3'h3;
    localparam logic [2:0] COMMON_1V25 = 3'h1;
    localparam logic [2:0] COMMON_SUPPLY = 3'h5;
    localparam logic [1:0] SLEEP_OFF = 2'h0;
    localparam logic [1:0] SLEEP_AUTO = 2'h1;
    localparam logic [1:0] SLEEP_FORCE = 2'h2;
    localparam logic [4:0] CABLE_MAX = 5'h19;
    localparam logic [4:0] CABLE_THRESHOLD = 5'h12;
    localparam logic READ_CMD = 1'b1;
    localparam logic WRITE_CMD = 1'b0;
    localparam int COMMAND_BITS = 8;
    localparam int FRAME_BITS = 16;
    localparam int CLOCK_NS = 4;
    localparam int SETTLE_US = 1000;
    localparam int SETTLE_CYCLES = (SETTLE_US * 1000 + CLOCK_NS - 1) / CLOCK_NS;
    localparam int SCK_HALF = 6;
endpackage

// ### inc/eqs_link_if.sv
/*
 holds the four-wire serial link between the equalizer register slave and its host.
 assumes the bench resolves miso from its enable; mosi has an enable since the host releases it.
*/
`timescale 1ns/1ns
interface eqs_link_if;
    logic sck;
    logic ssN;
    logic mosi;
    logic mosiOe;
    logic miso;
    logic misoOe;
    modport device (input sck, input ssN, input mosi, input mosiOe, output miso, output misoOe);
    modport host (output sck, output ssN, output mosi, output mosiOe, input miso, input misoOe);
endinterface

// ### rtl/eqs_device.sv
/*
 holds the equalizer's serial register slave: four registers, sampled link, analog controls out.
 assumes carrier and cable length arrive asynchronously from the analog front end.
*/
// Behaviour
// - read command is 1 then address msb first
// - ss low while eight command bits clock in
// - fetch after 8th rise, shift on 8th fall
// - host releases mosi, raises ss after read
// - reg 01h bits 7:5 swing, default 011
// - reg 01h bits 4:2 common mode, default 001
// - common-mode code 101 references positive supply
// - reg 02h bit 7 coarse launch amplitude
// - reg 02h bits 6:3 fine gain trim
// - reg 03h bits 7:3 cable length indicator
// - reg 00h bit 2 selects extended reach
// - power-up in normal reach mode
// - reg 00h bit 7 reads carrier status
// - mute bit 6 overrides bypass bit 5
// - sleep bits 4:3 override mute and bypass; here only forced sleep (10) does, auto sleep leaves them as set
// - host writes 00 to reg 00h bits 1:0
// - host keeps normal mode without carrier/long cable
// - host entry: sleep, set reach, wait, wake
// - host exit on carrier loss, same sequence
// - reach mode holds until host changes it
// - write is 0, address, data on sck rise
// - miso released throughout a write
`timescale 1ns/1ns
module eqs_device (
    input wire logic ref_clk,
    input wire logic rst,
    eqs_link_if.device link,
    input wire logic carrierIn,
    input wire logic [4:0] cableLengthIn,
    output logic [2:0] differentialOutputSwing,
    output logic [2:0] outputCommonModeVoltage,
    output logic supplyReferenced,
    output logic coarseLaunch,
    output logic [3:0] fineGain,
    output logic extendedReach,
    output logic outputMute,
    output logic eqBypass,
    output logic eqSleep
);
    ////////////////////////////////////////////////////////////////////////////
    logic [2:0] sckSync;
    logic [2:0] ssSync;
    logic [1:0] mosiSync;
    logic [1:0] carrierSync;
    logic [4:0] cableMeta;
    logic [4:0] cableSync;
    logic [4:0] cableHold;
    logic [4:0] cableLength;
    logic sckRise;
    logic sckFall;
    logic ssFall;
    logic ssHigh;

    logic [4:0] bitCount;
    logic [6:0] shiftIn;
    logic isRead;
    logic [7:0] shiftOut;
    logic [7:0] general;
    logic [7:0] driver;
    logic [7:0] launch;
    logic [7:0] readValue;
    logic [6:0] addrNow;
    logic [6:0] addrLatch;
    logic sleepForced;

    // only stage two and later are read
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sckSync <= 3'h0;
            // ss resets high so no false fall follows reset
            ssSync <= 3'h7;
            mosiSync <= 2'h0;
            carrierSync <= 2'h0;
            cableMeta <= 5'h00;
            cableSync <= 5'h00;
            cableHold <= 5'h00;
            cableLength <= 5'h00;
        end else begin
            sckSync <= {sckSync[1:0], link.sck};
            ssSync <= {ssSync[1:0], link.ssN};
            mosiSync <= {mosiSync[0], link.mosi};
            carrierSync <= {carrierSync[0], carrierIn};
            cableMeta <= cableLengthIn;
            cableSync <= cableMeta;
            cableHold <= cableSync;
            // bits may settle on different edges; take a value seen twice
            if (cableSync == cableHold) begin
                cableLength <= cableSync;
            end
        end
    end
    assign sckRise = sckSync[1] & ~sckSync[2];
    assign sckFall = ~sckSync[1] & sckSync[2];
    assign ssFall = ~ssSync[1] & ssSync[2];
    assign ssHigh = ssSync[1];
    assign addrNow = {shiftIn[5:0], mosiSync[1]};
    assign sleepForced = (general[4:3] == eqs_pkg::SLEEP_FORCE);

    ////////////////////////////////////////////////////////////////////////////
    // bit counter and command capture
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bitCount <= 5'h00;
            shiftIn <= 7'h00;
            isRead <= 1'b0;
            addrLatch <= 7'h00;
        end else if (ssHigh || ssFall) begin
            bitCount <= 5'h00;
        // clocks past the 16th are ignored until ss rises
        end else if (sckRise && bitCount < 5'(eqs_pkg::FRAME_BITS)) begin
            shiftIn <= {shiftIn[5:0], mosiSync[1]};
            bitCount <= bitCount + 5'h01;
            if (bitCount == 5'(eqs_pkg::COMMAND_BITS - 1)) begin
                addrLatch <= addrNow;
            end
            if (bitCount == 5'h00) begin
                isRead <= (mosiSync[1] == eqs_pkg::READ_CMD);
            end
        end
    end

    // unmapped addresses read as zero
    always_comb begin
        case (addrNow)
            eqs_pkg::REG_GENERAL: readValue = {carrierSync[1], general[6:0]};
            eqs_pkg::REG_DRIVER: readValue = driver;
            eqs_pkg::REG_LAUNCH: readValue = launch;
            eqs_pkg::REG_CABLE: readValue = {cableLength, 3'h0};
            default: readValue = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // read path: fetch on 8th rise, present msb on 8th fall
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            shiftOut <= 8'h00;
            link.misoOe <= 1'b0;
            link.miso <= 1'b0;
        end else if (ssHigh) begin
            link.misoOe <= 1'b0;
        end else begin
            if (sckRise && bitCount == 5'(eqs_pkg::COMMAND_BITS - 1) && isRead) begin
                shiftOut <= readValue;
            end
            // the 16th fall shifts out a trailing zero the host never samples
            if (sckFall && isRead && bitCount >= 5'(eqs_pkg::COMMAND_BITS)) begin
                link.misoOe <= 1'b1;
                link.miso <= shiftOut[7];
                shiftOut <= {shiftOut[6:0], 1'b0};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register writes on the 16th rise; mode holds until rewritten
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            general <= eqs_pkg::GENERAL_RESET;
            driver <= eqs_pkg::DRIVER_RESET;
            launch <= eqs_pkg::LAUNCH_RESET;
        end else if (!ssHigh && sckRise && !isRead
                && bitCount == 5'(eqs_pkg::FRAME_BITS - 1)) begin
            case (addrLatch)
                // carrier and the reserved low bits are not stored
                eqs_pkg::REG_GENERAL: general <= {1'b0, shiftIn[5:1], 2'h0};
                eqs_pkg::REG_DRIVER: driver <= {shiftIn, mosiSync[1]};
                eqs_pkg::REG_LAUNCH: launch <= {shiftIn, mosiSync[1]};
                default: begin
                    // cable length is read only; other writes are dropped
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // analog controls, registered
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            // reset values mirror the register defaults
            differentialOutputSwing <= eqs_pkg::SWING_700MV;
            outputCommonModeVoltage <= eqs_pkg::COMMON_1V25;
            supplyReferenced <= 1'b0;
            coarseLaunch <= 1'b0;
            fineGain <= 4'h0;
            extendedReach <= 1'b0;
            outputMute <= 1'b0;
            eqBypass <= 1'b0;
            eqSleep <= 1'b0;
        end else begin
            differentialOutputSwing <= driver[eqs_pkg::SWING_LO +: 3];
            outputCommonModeVoltage <= driver[eqs_pkg::COMMON_LO +: 3];
            supplyReferenced <= (driver[eqs_pkg::COMMON_LO +: 3] == eqs_pkg::COMMON_SUPPLY);
            coarseLaunch <= launch[eqs_pkg::COARSE_BIT];
            fineGain <= launch[eqs_pkg::FINE_LO +: 4];
            extendedReach <= general[eqs_pkg::REACH_BIT];
            // forced sleep wins over mute, mute over bypass; reserved 11 treated as awake
            eqSleep <= sleepForced
                || (general[4:3] == eqs_pkg::SLEEP_AUTO && !carrierSync[1]);
            outputMute <= general[eqs_pkg::MUTE_BIT] && !sleepForced;
            eqBypass <= general[eqs_pkg::BYPASS_BIT] && !general[eqs_pkg::MUTE_BIT]
                && !sleepForced;
        end
    end
endmodule

// ### rtl/eqs_host.sv
/*
 holds the host controller: avalon-mm registers for software, serial master, reach sequencer.
 assumes a single ref_clk; sck is divided down from it and driven out.
*/
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ns
module eqs_host #(
    parameter int SETTLE_CYCLES = eqs_pkg::SETTLE_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    eqs_link_if.host link,
    input wire logic [2:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    // 0 cmd: bit16 start, bit15 read, 14:8 addr, 7:0 data
    // 1 status: bit0 busy, 15:8 last read; 2 auto: bit0 enable; 3 reach state
    localparam logic [2:0] OFS_CMD = eqs_pkg::HOST_CMD;
    localparam logic [2:0] OFS_STATUS = eqs_pkg::HOST_STATUS;
    localparam logic [2:0] OFS_AUTO = eqs_pkg::HOST_AUTO;
    localparam logic [2:0] OFS_REACH = eqs_pkg::HOST_REACH;

    typedef enum logic [1:0] {
        XF_IDLE = 2'b00, XF_SHIFT = 2'b01, XF_DONE = 2'b10
    } eqs_xfer_t;
    typedef enum logic [3:0] {
        SQ_POLL = 4'h0, SQ_READ_GEN = 4'h1, SQ_READ_CBL = 4'h2, SQ_SLEEP = 4'h3,
        SQ_REACH = 4'h4, SQ_WAIT = 4'h5, SQ_WAKE = 4'h6, SQ_IDLE = 4'h7
    } eqs_seq_t;

    ////////////////////////////////////////////////////////////////////////////
    logic [1:0] misoSync;
    eqs_xfer_t xferState;
    eqs_seq_t seqState;
    logic [3:0] divCount;
    logic [4:0] bitCount;
    logic [15:0] txShift;
    logic [7:0] rxShift, lastRead;
    logic xferRead, xferStart, xferDone;
    logic [15:0] xferWord;
    logic autoEnable, inReach;
    logic [31:0] waitCount;
    logic [7:0] generalImage;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) misoSync <= 2'h0;
        else misoSync <= {misoSync[0], link.miso};
    end

    ////////////////////////////////////////////////////////////////////////////
    // serial master; sck idles low, data changes on falls
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            xferState <= XF_IDLE;
            divCount <= 4'h0;
            bitCount <= 5'h00;
            txShift <= 16'h0000;
            rxShift <= 8'h00;
            link.sck <= 1'b0;
            link.ssN <= 1'b1;
            link.mosi <= 1'b0;
            link.mosiOe <= 1'b0;
            xferDone <= 1'b0;
        end else begin
            xferDone <= 1'b0;
            case (xferState)
                XF_IDLE: begin
                    if (xferStart) begin
                        txShift <= xferWord;
                        link.ssN <= 1'b0;
                        link.mosiOe <= 1'b1;
                        link.mosi <= xferWord[15];
                        bitCount <= 5'h00;
                        divCount <= 4'h0;
                        xferState <= XF_SHIFT;
                    end
                end
                XF_SHIFT: begin
                    divCount <= divCount + 4'h1;
                    if (divCount == 4'(eqs_pkg::SCK_HALF - 1)) begin
                        divCount <= 4'h0;
                        link.sck <= ~link.sck;
                        if (!link.sck) begin
                            bitCount <= bitCount + 5'h01;
                            if (bitCount >= 5'(eqs_pkg::COMMAND_BITS)) begin
                                rxShift <= {rxShift[6:0], misoSync[1]};
                            end
                            if (xferRead && bitCount == 5'(eqs_pkg::COMMAND_BITS - 1)) begin
                                link.mosiOe <= 1'b0;
                            end
                        end else begin
                            txShift <= {txShift[14:0], 1'b0};
                            link.mosi <= txShift[14];
                            if (bitCount == 5'(eqs_pkg::FRAME_BITS)) begin
                                xferState <= XF_DONE;
                            end
                        end
                    end
                end
                XF_DONE: begin
                    // ss stays high a half period so miso is released before the next frame
                    link.ssN <= 1'b1;
                    link.mosiOe <= 1'b0;
                    divCount <= divCount + 4'h1;
                    if (divCount == 4'(eqs_pkg::SCK_HALF - 1)) begin
                        xferDone <= 1'b1;
                        xferState <= XF_IDLE;
                    end
                end
                default: xferState <= XF_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // software port and extended reach sequencer share the serial master
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            seqState <= SQ_IDLE;
            xferStart <= 1'b0;
            xferRead <= 1'b0;
            xferWord <= 16'h0000;
            autoEnable <= 1'b0;
            inReach <= 1'b0;
            waitCount <= 32'h0;
            lastRead <= 8'h00;
            generalImage <= eqs_pkg::GENERAL_RESET;
            avs_readdata <= 32'h0;
            avs_waitrequest <= 1'b1;
        end else begin
            xferStart <= 1'b0;
            avs_waitrequest <= 1'b1;
            if (xferDone && xferRead) lastRead <= rxShift;
            if (avs_read && avs_waitrequest) begin
                avs_waitrequest <= 1'b0;
                case (avs_address)
                    OFS_STATUS: avs_readdata <= {16'h0, lastRead, 7'h0,
                        (xferState != XF_IDLE) || xferStart || xferDone};
                    OFS_AUTO: avs_readdata <= {31'h0, autoEnable};
                    OFS_REACH: avs_readdata <= {24'h0, seqState, 3'h0, inReach};
                    default: avs_readdata <= 32'h0;
                endcase
            end else if (avs_write && avs_waitrequest) begin
                // commands wait while a transfer is running
                if (avs_address == OFS_CMD && (xferState != XF_IDLE || xferStart
                        || seqState != SQ_IDLE && seqState != SQ_POLL && seqState != SQ_WAIT)) begin
                    avs_waitrequest <= 1'b1;
                end else begin
                    avs_waitrequest <= 1'b0;
                    if (avs_address == OFS_CMD && avs_writedata[16]) begin
                        xferRead <= avs_writedata[15];
                        // reserved bits of the general register forced to zero
                        xferWord <= {avs_writedata[15:8], avs_writedata[7:2],
                            (avs_writedata[14:8] == eqs_pkg::REG_GENERAL && !avs_writedata[15])
                            ? 2'h0 : avs_writedata[1:0]};
                        xferStart <= 1'b1;
                    end
                    if (avs_address == OFS_AUTO) begin
                        autoEnable <= avs_writedata[0];
                        seqState <= avs_writedata[0] ? SQ_POLL : SQ_IDLE;
                    end
                end
            end
            if (!(avs_write && avs_waitrequest && avs_address == OFS_AUTO)) begin
                case (seqState)
                    SQ_IDLE: begin
                    end
                    SQ_POLL: if (xferState == XF_IDLE && !xferStart && !avs_write) begin
                        xferRead <= 1'b1;
                        xferWord <= {eqs_pkg::READ_CMD, eqs_pkg::REG_GENERAL, 8'h00};
                        xferStart <= 1'b1;
                        seqState <= SQ_READ_GEN;
                    end
                    SQ_READ_GEN: if (xferDone) begin
                        generalImage <= {1'b0, rxShift[6:2], 2'h0};
                        if (!rxShift[eqs_pkg::CARRIER_BIT] && inReach) begin
                            seqState <= SQ_SLEEP;
                        end else if (!rxShift[eqs_pkg::CARRIER_BIT] || inReach) begin
                            seqState <= SQ_POLL;
                        end else begin
                            xferWord <= {eqs_pkg::READ_CMD, eqs_pkg::REG_CABLE, 8'h00};
                            xferStart <= 1'b1;
                            seqState <= SQ_READ_CBL;
                        end
                    end
                    SQ_READ_CBL: if (xferDone) begin
                        if (rxShift[7:3] < eqs_pkg::CABLE_THRESHOLD) seqState <= SQ_SLEEP;
                        else seqState <= SQ_POLL;
                    end
                    SQ_SLEEP: if (xferState == XF_IDLE && !xferStart) begin
                        xferRead <= 1'b0;
                        generalImage[4:3] <= eqs_pkg::SLEEP_FORCE;
                        xferWord <= {eqs_pkg::WRITE_CMD, eqs_pkg::REG_GENERAL,
                            generalImage[7:5], eqs_pkg::SLEEP_FORCE, generalImage[2:0]};
                        xferStart <= 1'b1;
                        seqState <= SQ_REACH;
                    end
                    SQ_REACH: if (xferDone) begin
                        generalImage[2] <= ~inReach;
                        xferWord <= {eqs_pkg::WRITE_CMD, eqs_pkg::REG_GENERAL,
                            generalImage[7:3], ~inReach, 2'h0};
                        xferStart <= 1'b1;
                        waitCount <= 32'h0;
                        seqState <= SQ_WAIT;
                    end
                    SQ_WAIT: if (xferState == XF_IDLE && !xferStart) begin
                        waitCount <= waitCount + 32'h1;
                        if (waitCount >= 32'(SETTLE_CYCLES)) begin
                            inReach <= ~inReach;
                            xferWord <= {eqs_pkg::WRITE_CMD, eqs_pkg::REG_GENERAL,
                                generalImage[7:5], eqs_pkg::SLEEP_AUTO, generalImage[2:0]};
                            xferStart <= 1'b1;
                            seqState <= SQ_WAKE;
                        end
                    end
                    SQ_WAKE: if (xferDone) seqState <= SQ_POLL;
                    default: seqState <= SQ_IDLE;
                endcase
            end
        end
    end
endmodule

// ### test/eqs_link_assertions.sv
/*
 link checker for the host and register slave.
 assumes it sits beside the link interface in the bench.
*/
`timescale 1ns/1ns
module eqs_link_assertions (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sck,
    input wire logic ssN,
    input wire logic mosi,
    input wire logic mosiOe,
    input wire logic miso,
    input wire logic misoOe
);
    logic [4:0] cnt;
    logic sckQ;
    logic cmdBit;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////
    // sck rises per frame; sck is slow enough to sample raw
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt <= 5'h00;
            sckQ <= 1'b0;
            cmdBit <= 1'b0;
        end else begin
            sckQ <= sck;
            if (ssN) begin
                cnt <= 5'h00;
            end else if (sck && !sckQ) begin
                cnt <= cnt + 5'h01;
                if (cnt == 5'h00) begin
                    cmdBit <= mosi;
                end
            end
        end
    end
    ////////////////////////////////////////////////////////////
    // device syncs ss, so allow a few cycles
    a_miso_idle: assert property (ssN [*4] |-> !misoOe)
        else $error("miso enabled while deselected");
    a_sck_idle: assert property (ssN |-> !sck)
        else $error("sck high outside frame");
    a_oe_exclusive: assert property (misoOe |-> !mosiOe)
        else $error("both ends drive");
    a_write_quiet: assert property (misoOe |-> cmdBit)
        else $error("miso enabled in write");
    a_data_start: assert property ($rose(misoOe) |-> cnt == 5'h08)
        else $error("read data not after 8th clock");
    a_frame_len: assert property ($rose(ssN) |-> cnt == 5'h10)
        else $error("frame not 16 clocks");
    a_mosi_stable: assert property (sck && $past(sck) && mosiOe && $past(mosiOe) |-> $stable(mosi))
        else $error("mosi moved while sck high");
    a_mosi_release: assert property (cmdBit && cnt == 5'h08 && !sck && !ssN |-> !mosiOe)
        else $error("mosi held after 8th clock");
    a_miso_stable: assert property (misoOe && $past(misoOe) && sck && $past(sck) |-> $stable(miso))
        else $error("miso moved while sck high");
endmodule

// ### test/eqs_control_regs_tb.sv
/*
 bench joining host and register slave over the link; drives avalon and analog inputs.
 assumes eqs_pkg, eqs_link_if and both design ends are compiled first.
*/
`timescale 1ns/1ns
module eqs_control_regs_tb;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic carrierIn = 1'b1;
    logic [4:0] cableLengthIn = 5'h07;
    logic [2:0] avsAddress = 3'h0;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWritedata = 32'h0;
    logic [31:0] avsReaddata;
    logic avsWaitrequest;
    logic [2:0] swing;
    logic [2:0] common;
    logic [3:0] fine;
    logic supplyRef, coarse, reach, mute, bypass, sleep;
    logic [31:0] q;
    int mismatches = 0;
    int tests_run = 0;
    wire [15:0] outs = {swing, common, supplyRef, coarse, fine, reach, mute, bypass, sleep};
    eqs_link_if link();
    eqs_device eqs_device_inst (.ref_clk(ref_clk), .rst(rst), .link(link), .carrierIn(carrierIn),
        .cableLengthIn(cableLengthIn), .differentialOutputSwing(swing),
        .outputCommonModeVoltage(common), .supplyReferenced(supplyRef), .coarseLaunch(coarse),
        .fineGain(fine), .extendedReach(reach), .outputMute(mute), .eqBypass(bypass),
        .eqSleep(sleep));
    // short settle so the reach sequence fits the run
    eqs_host #(.SETTLE_CYCLES(50)) eqs_host_inst (.ref_clk(ref_clk), .rst(rst), .link(link),
        .avs_address(avsAddress), .avs_read(avsRead), .avs_write(avsWrite),
        .avs_writedata(avsWritedata), .avs_readdata(avsReaddata),
        .avs_waitrequest(avsWaitrequest));
    eqs_link_assertions chk_inst (.ref_clk(ref_clk), .rst(rst), .sck(link.sck), .ssN(link.ssN),
        .mosi(link.mosi), .mosiOe(link.mosiOe), .miso(link.miso), .misoOe(link.misoOe));
    always #2 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] e, input logic [15:0] got);
        tests_run++;
        if (got !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, e, got);
        end
    endtask
    task automatic limit(input int n, input int lim);
        if (n >= lim) begin
            mismatches++;
            $display("[ERR] wait expected done seen timeout");
            end_sim();
        end
    endtask
    // one avalon access; request held until waitrequest is sampled low
    task automatic bus(input logic [2:0] a, input logic wr, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        avsAddress <= a;
        avsRead <= ~wr;
        avsWrite <= wr;
        avsWritedata <= d;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avsWaitrequest !== 1'b0 && n < 4000);
        q = avsReaddata;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
        limit(n, 4000);
    endtask
    task automatic spi(input logic rd, input logic [6:0] a, input logic [7:0] d);
        int n;
        n = 0;
        bus(3'h0, 1'b1, {15'h0, 1'b1, rd, a, d});
        do begin
            bus(3'h1, 1'b0, 32'h0);
            n++;
        end while (q[0] !== 1'b0 && n < 500);
        limit(n, 500);
    endtask
    task automatic rchk(input logic [6:0] a, input logic [7:0] e);
        spi(1'b1, a, 8'h00);
        check("serial read", {8'h00, e}, {8'h00, q[15:8]});
    endtask
    task automatic wait_ctl(input logic [1:0] v);
        int n;
        n = 0;
        while ({reach, sleep} !== v && n < 8000) begin
            @(posedge ref_clk);
            n++;
        end
        limit(n, 8000);
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        check("power-up controls", 16'h6400, outs);
        rchk(7'h00, 8'h88);
        rchk(7'h01, 8'h64);
        rchk(7'h02, 8'h00);
        rchk(7'h03, 8'h38);
        rchk(7'h05, 8'h00);
        spi(1'b0, 7'h01, 8'h94);
        check("driver controls", 16'h9600, outs);
        rchk(7'h01, 8'h94);
        spi(1'b0, 7'h02, 8'hd0);
        check("launch controls", 16'h97a0, outs);
        spi(1'b0, 7'h03, 8'hff);
        cableLengthIn <= 5'h19;
        rchk(7'h03, 8'hc8);
        spi(1'b0, 7'h00, 8'hff);
        rchk(7'h00, 8'hfc);
        check("reserved sleep", 16'h0006, {13'h0, reach, mute, sleep});
        spi(1'b0, 7'h00, 8'h20);
        check("bypass only", 16'h0002, {12'h0, reach, mute, bypass, sleep});
        spi(1'b0, 7'h00, 8'h70);
        check("forced sleep", 16'h0001, {12'h0, reach, mute, bypass, sleep});
        carrierIn <= 1'b0;
        spi(1'b0, 7'h00, 8'h08);
        check("auto sleep", 16'h0001, {14'h0, reach, sleep});
        spi(1'b0, 7'h00, 8'h00);
        check("sleep off", 16'h0000, {14'h0, reach, sleep});
        // cable swap while reach is on; no host sequence is enabled yet
        spi(1'b0, 7'h00, 8'h04);
        carrierIn <= 1'b1;
        cableLengthIn <= 5'h02;
        repeat (20) @(posedge ref_clk);
        carrierIn <= 1'b0;
        rchk(7'h00, 8'h04);
        check("reach held", 16'h0001, {15'h0, reach});
        spi(1'b0, 7'h00, 8'h08);
        carrierIn <= 1'b1;
        cableLengthIn <= 5'h13;
        bus(3'h2, 1'b1, 32'h1);
        bus(3'h2, 1'b0, 32'h0);
        check("auto enable", 16'h0001, {15'h0, q[0]});
        repeat (1500) @(posedge ref_clk);
        check("long cable", 16'h0000, {15'h0, reach});
        cableLengthIn <= 5'h05;
        wait_ctl(2'b10);
        carrierIn <= 1'b0;
        wait_ctl(2'b01);
        bus(3'h7, 1'b0, 32'h0);
        check("unmapped host word", 16'h0000, q[15:0]);
        end_sim();
    end
endmodule
